// *** core/bmoc_control.sv ***
// mode, frequency, valley clamp, undervoltage reaction and compensation registers
// assumes a simple byte register port driven by the serial host front end
`timescale 1ns/10ps
`include "bmoc_cfg.svh"
// What this block does
// RULE1: two-bit code picks 600k to 1.2M switching
// RULE2: select bit set forces continuous, else auto-skip
// RULE3: mode select captured, frozen while enabled
// RULE4: write acknowledged while enabled, applied after toggle
// RULE5: hold low side, delay high side above limit
// RULE6: clamp action sets valley limit flag
// RULE7: no direct shutdown on clamp
// RULE8: after delay, react by retry select bit
// RULE9: retry zero latches drivers off until toggle
// RULE10: retry one sleeps 56 ms, restarts forever
// RULE11: clamp stays active during soft-start
// RULE12: undervoltage comparator ignored during soft-start
// RULE13: telemetry averages low-side current per on-time
// RULE14: compensation fields independently writable
// RULE15: recovery above threshold zeroes delay counter
// RULE16: trip flag set when delay starts
// RULE17: hiccup restart goes through soft-start again
// RULE18: host writes settings before enabling
module bmoc_control #(
  parameter int          CUR_W      = 12,
  parameter int unsigned HICCUP_CYC = `BMOC_HICCUP_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // register port
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire bmoc_pkg::bmoc_byte_t reg_wdata,
  output bmoc_pkg::bmoc_byte_t    reg_rdata,
  output logic                    reg_ack,
  // enable pin and power stage sense
  input  wire logic               enable_pin,
  input  wire logic               soft_start_done,
  input  wire logic               uv_below,
  input  wire logic               low_over_limit,
  input  wire logic               cycle_end,
  input  wire logic               low_on,
  input  wire logic [CUR_W-1:0]   low_current,
  // power stage control
  output logic                    convert_on,
  output logic                    soft_start_go,
  output logic                    hold_low_on,
  output logic                    block_high_on,
  output logic                    forced_continuous_select,
  output logic [1:0]              fsw_code,
  output logic [23:0]             fsw_step,
  output logic [CUR_W-1:0]        output_current_reading,
  output bmoc_pkg::bmoc_byte_t    loop_gain_out,
  output bmoc_pkg::bmoc_byte_t    integrator_ramp_out,
  output bmoc_pkg::bmoc_byte_t    load_line_out
);
  import bmoc_pkg::*;
  // the sleep counter cannot serve a zero-length hiccup
  initial if (HICCUP_CYC < 1) $error("bmoc_control: hiccup count must be positive");
  // the averager divides a sum of this width, so keep it modest
  initial if (CUR_W < 2 || CUR_W > 24) $error("bmoc_control: current width out of range");

  // registers written by the host
  // every field is a whole byte so a single write never disturbs a neighbour
  bmoc_byte_t  switching_rate_select;
  bmoc_byte_t  undervoltage_reaction_config;
  bmoc_byte_t  system_user_config;
  bmoc_byte_t  loop_gain_config;
  bmoc_byte_t  integrator_ramp_config;
  bmoc_byte_t  load_line_config;
  // status
  logic        valley_limit_flag;
  logic        undervoltage_trip;
  // control state
  bmoc_state_t state;
  bmoc_state_t next_state;
  logic        enable_q;
  logic [31:0] dly_cnt;
  logic [31:0] sleep_cnt;
  logic        mode_latched;

  // address decode
  // one compare per register; the status addresses decode for reads only
  // unmapped addresses select nothing and read back as zero
  wire sel_rate   = reg_addr == `BMOC_ADDR_RATE;
  wire sel_uv     = reg_addr == `BMOC_ADDR_UVREACT;
  wire sel_cur    = reg_addr == `BMOC_ADDR_CURSTAT;
  wire sel_vout   = reg_addr == `BMOC_ADDR_VOUTSTAT;
  wire sel_sys    = reg_addr == `BMOC_ADDR_SYSCFG;
  wire sel_gain   = reg_addr == `BMOC_ADDR_LOOPGAIN;
  wire sel_ramp   = reg_addr == `BMOC_ADDR_INTRAMP;
  wire sel_ll     = reg_addr == `BMOC_ADDR_LOADLINE;
  wire en_rise    = enable_pin && !enable_q;
  wire en_fall    = !enable_pin && enable_q;
  wire retry_sel  = undervoltage_reaction_config[`BMOC_RETRY_BIT];
  // delay length: lower three bits in units, zero means immediate
  wire [31:0] dly_lim = 32'(undervoltage_reaction_config[2:0]) * 32'(`BMOC_UVDLY_UNIT);
  // comparator only counts after soft-start, in run state
  wire uv_live    = (state == bmoc_run_s) && uv_below; // RULE12 RULE17
  wire uv_expire  = uv_live && (dly_cnt >= dly_lim); // RULE8
  wire clamp      = convert_on && low_over_limit; // RULE11

  // read mux
  // combinational, so data is valid in the same cycle as the read strobe
  // the host must hold the address for that cycle or it reads a neighbour
  always_comb
  begin
    reg_rdata = 8'h00;
    if (sel_rate)
      reg_rdata = switching_rate_select;
    else if (sel_uv)
      reg_rdata = undervoltage_reaction_config;
    else if (sel_cur)
      reg_rdata = {7'h00, valley_limit_flag};
    else if (sel_vout)
      reg_rdata = {7'h00, undervoltage_trip};
    else if (sel_sys)
      reg_rdata = system_user_config;
    else if (sel_gain)
      reg_rdata = loop_gain_config;
    else if (sel_ramp)
      reg_rdata = integrator_ramp_config;
    else if (sel_ll)
      reg_rdata = load_line_config;
  end
  // every access is acknowledged, including mode writes while enabled
  assign reg_ack = reg_wr || reg_rd; // RULE4

  // host writes; compensation fields are separate bytes
  // writes to status or unmapped addresses fall through and are dropped
  // the mode byte is stored at once; its effect waits for an enable toggle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      switching_rate_select        <= `BMOC_RST_RATE;
      undervoltage_reaction_config <= `BMOC_RST_UVREACT;
      system_user_config           <= `BMOC_RST_SYSCFG;
      loop_gain_config             <= `BMOC_RST_COMP;
      integrator_ramp_config       <= `BMOC_RST_COMP;
      load_line_config             <= `BMOC_RST_COMP;
    end
    else if (reg_wr)
    begin
      if (sel_rate)
        switching_rate_select <= reg_wdata;
      else if (sel_uv)
        undervoltage_reaction_config <= reg_wdata;
      else if (sel_sys)
        system_user_config <= reg_wdata;
      else if (sel_gain)
        loop_gain_config <= reg_wdata; // RULE14
      else if (sel_ramp)
        integrator_ramp_config <= reg_wdata; // RULE14
      else if (sel_ll)
        load_line_config <= reg_wdata; // RULE14
    end
  end

  // status flags: set beats a clear on read of the same cycle
  // a clamp that lands in the read cycle must not be lost, so set wins
  // the trip flag marks the first cycle of the delay count
  // flags stay sticky until the host reads them back
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      valley_limit_flag <= 1'b0;
      undervoltage_trip <= 1'b0;
    end
    else
    begin
      if (clamp)
        valley_limit_flag <= 1'b1; // RULE6
      else if (reg_rd && sel_cur)
        valley_limit_flag <= 1'b0;
      if (uv_live && dly_cnt == 32'h0)
        undervoltage_trip <= 1'b1; // RULE16
      else if (reg_rd && sel_vout)
        undervoltage_trip <= 1'b0;
    end
  end

  // next state: the clamp never leads here directly, only the uv path
  // enable low always wins and returns to off from any state
  // latch is left only by enable low; hiccup leaves by itself
  always_comb
  begin
    next_state = state;
    case (state)
      bmoc_off_s:
        if (enable_pin)
          next_state = bmoc_soft_s;
      bmoc_soft_s:
        if (!enable_pin)
          next_state = bmoc_off_s;
        else if (soft_start_done)
          next_state = bmoc_run_s;
      bmoc_run_s:
        if (!enable_pin)
          next_state = bmoc_off_s;
        else if (uv_expire) // RULE7
          next_state = retry_sel ? bmoc_hiccup_s : bmoc_latch_s; // RULE8
      bmoc_latch_s:
        if (!enable_pin)
          next_state = bmoc_off_s; // RULE9
      bmoc_hiccup_s:
        if (!enable_pin)
          next_state = bmoc_off_s;
        else if (sleep_cnt >= HICCUP_CYC - 1)
          next_state = bmoc_soft_s; // RULE10 RULE17
      default:
        next_state = bmoc_off_s;
    endcase
  end

  // state, delay and sleep counters
  // the delay count only runs while the comparator is live in run state
  // the sleep count restarts each time hiccup is entered
  // 32-bit counters cover the full hiccup time at this clock rate
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state     <= bmoc_off_s;
      enable_q  <= 1'b0;
      dly_cnt   <= 32'h0;
      sleep_cnt <= 32'h0;
    end
    else
    begin
      state    <= next_state;
      enable_q <= enable_pin;
      // rising back above threshold zeroes the count
      dly_cnt  <= uv_live && !uv_expire ? dly_cnt + 32'h1 : 32'h0; // RULE15
      sleep_cnt <= (state == bmoc_hiccup_s) ? sleep_cnt + 32'h1 : 32'h0; // RULE10
    end
  end

  // mode select follows the register only while disabled
  // freezing it while enabled avoids a mode change mid-conversion
  // a write while enabled is kept and applied at the next disable
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_latched <= 1'b0;
    else if (!enable_pin || en_fall)
      mode_latched <= system_user_config[`BMOC_FORCED_CONTINUOUS_SELECT_BIT]; // RULE3 RULE4
  end
  assign forced_continuous_select = mode_latched; // RULE2

  // frequency: code to period step for a phase accumulator downstream
  // steps are whole clocks, so all rates but 1M carry a small rounding error
  // upper bits of the rate byte are stored but do not affect the rate
  assign fsw_code = switching_rate_select[1:0]; // RULE1
  always_comb
  begin
    case (fsw_code)
      2'b00:   fsw_step = 24'(`BMOC_CLK_HZ / `BMOC_FSW_600K_HZ);
      2'b01:   fsw_step = 24'(`BMOC_CLK_HZ / `BMOC_FSW_800K_HZ);
      2'b10:   fsw_step = 24'(`BMOC_CLK_HZ / `BMOC_FSW_1M_HZ);
      default: fsw_step = 24'(`BMOC_CLK_HZ / `BMOC_FSW_1M2_HZ);
    endcase
  end

  // drivers: latch and hiccup force both off
  // convert_on gates both switches, so off states stop all switching
  assign convert_on    = (state == bmoc_soft_s) || (state == bmoc_run_s); // RULE9
  assign soft_start_go = (state == bmoc_soft_s) && !en_rise;
  // valley clamp extends the off-time cycle by cycle
  assign hold_low_on   = clamp; // RULE5
  assign block_high_on = clamp && !cycle_end ? 1'b1 : clamp; // RULE5

  // compensation outputs
  // passed straight to the analog loop; no field here changes the logic
  assign loop_gain_out       = loop_gain_config;
  assign integrator_ramp_out = integrator_ramp_config;
  assign load_line_out       = load_line_config;

  // telemetry averager
  // averaging over the whole on-time gives load current, not a valley
  // the reading holds its last value while conversion is off
  bmoc_low_side_avg #(
    .W(CUR_W)
  ) u_avg (
    .clk     (clk),
    .rst_b   (rst_b),
    .low_on  (low_on),
    .sample  (low_current),
    .average (output_current_reading),
    .done    ()
  );
endmodule

// *** core/bmoc_cfg.svh ***
// constants for the buck mode and overcurrent control block: offsets, fields, timing
// assumes inclusion by bare name from the package and from bmoc_control
`ifndef BMOC_CFG_SVH
`define BMOC_CFG_SVH
`define BMOC_ADDR_RATE      8'h33
`define BMOC_ADDR_UVREACT   8'h45
`define BMOC_ADDR_CURSTAT   8'h7B
`define BMOC_ADDR_VOUTSTAT  8'h7A
`define BMOC_ADDR_SYSCFG    8'hA0
`define BMOC_ADDR_LOOPGAIN  8'hA9
`define BMOC_ADDR_INTRAMP   8'hAA
`define BMOC_ADDR_LOADLINE  8'hAD
`define BMOC_RETRY_BIT      3
`define BMOC_FORCED_CONTINUOUS_SELECT_BIT       0
`define BMOC_VLIM_BIT       0
`define BMOC_UVT_BIT        0
`define BMOC_CLK_HZ         125000000
`define BMOC_HICCUP_MS      56
`define BMOC_HICCUP_CYC     ((`BMOC_CLK_HZ / 1000) * `BMOC_HICCUP_MS)
`define BMOC_FSW_600K_HZ    600000
`define BMOC_FSW_800K_HZ    800000
`define BMOC_FSW_1M_HZ      1000000
`define BMOC_FSW_1M2_HZ     1200000
`define BMOC_UVDLY_UNIT     1250
`define BMOC_RST_RATE       8'h00
`define BMOC_RST_UVREACT    8'h00
`define BMOC_RST_SYSCFG     8'h00
`define BMOC_RST_COMP       8'h00
`endif

// *** core/bmoc_pkg.sv ***
// types for the buck mode and overcurrent control block
// assumes bmoc_cfg.svh on the include path
`include "bmoc_cfg.svh"
package bmoc_pkg;
  typedef enum logic [2:0] {
    bmoc_off_s     = 3'b000,
    bmoc_soft_s    = 3'b001,
    bmoc_run_s     = 3'b011,
    bmoc_latch_s   = 3'b010,
    bmoc_hiccup_s  = 3'b110
  } bmoc_state_t;
  typedef logic [7:0] bmoc_byte_t;
endpackage

// *** core/bmoc_low_side_avg.sv ***
// averages the low-side switch current over each low-side on-time
// assumes samples are synchronous to clk and valid while low_on is high
`timescale 1ns/10ps
module bmoc_low_side_avg #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // sampling
  input  wire logic         low_on,
  input  wire logic [W-1:0] sample,
  // result
  output logic      [W-1:0] average,
  output logic              done
);
  initial if (W < 2 || W > 24) $error("bmoc_low_side_avg: width out of range");
  logic [W+15:0] sum;   // running sum within one on-time
  logic [15:0]   cnt;   // samples taken
  logic          low_on_q;
  wire           fin = low_on_q && !low_on;
  wire [W+15:0]  quo = (cnt == 16'h0000) ? '0 : sum / {{W{1'b0}}, cnt};
  // accumulate from start to end of the on-time, never a peak or valley
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sum      <= '0;
      cnt      <= 16'h0000;
      low_on_q <= 1'b0;
      average  <= '0;
      done     <= 1'b0;
    end
    else
    begin
      low_on_q <= low_on;
      done     <= fin;
      if (low_on && !low_on_q)
      begin
        sum <= {16'h0000, sample};
        cnt <= 16'h0001;
      end
      else if (low_on && cnt != 16'hFFFF)
      begin
        sum <= sum + {16'h0000, sample};
        cnt <= cnt + 16'h0001;
      end
      if (fin)
        average <= quo[W-1:0]; // RULE13
    end
  end
endmodule

// *** testbench/bmoc_chk_asserts.sv ***
// checker on the ports of bmoc_control
// assumes one clk domain, rst_b async active low
`timescale 1ns/10ps
module bmoc_chk (
  // host side
  input wire logic clk, rst_b, reg_wr,
  input wire logic [7:0] reg_addr,
  input wire bmoc_pkg::bmoc_byte_t reg_wdata, loop_gain_out,
  // stage side
  input wire logic enable_pin, soft_start_done, uv_below, low_over_limit,
  input wire logic convert_on, soft_start_go, hold_low_on, block_high_on,
  input wire logic forced_continuous_select,
  input wire logic [1:0] fsw_code,
  input wire logic [23:0] fsw_step
);
  import bmoc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_CLAMP: assert property (
    convert_on && low_over_limit |-> hold_low_on && block_high_on)
    else $error("clamp missing");
  AST_FSW_STEP: assert property (
    fsw_step == 24'(125000000 / (600000 + 200000 * int'(fsw_code))))
    else $error("bad step");
  AST_FSW_WR: assert property (
    reg_wr && reg_addr == 8'h33 |=> fsw_code == $past(reg_wdata[1:0]))
    else $error("rate not written");
  // mode must not move while conversion runs
  AST_MODE_HELD: assert property (
    enable_pin && $past(enable_pin) |-> $stable(forced_continuous_select))
    else $error("mode moved");
  AST_NO_DIRECT_OFF: assert property (
    $fell(convert_on) |-> !$past(enable_pin) || $past(uv_below))
    else $error("off without uv");
  AST_SS_BLANK: assert property (
    soft_start_go && enable_pin && !soft_start_done |=> convert_on)
    else $error("uv in soft-start");
  AST_RESTART_SS: assert property (
    $rose(convert_on) |-> soft_start_go)
    else $error("no soft-start");
  AST_COMP_WR: assert property (
    reg_wr && reg_addr == 8'hA9 |=> loop_gain_out == $past(reg_wdata))
    else $error("gain not written");
  cover property (hold_low_on && soft_start_go);
  cover property ($fell(convert_on) && enable_pin);
  cover property ($rose(soft_start_go) && enable_pin);
endmodule
bind bmoc_control bmoc_chk u_chk (.*);

// *** testbench/bmoc_stage_model.sv ***
// power stage and output model facing bmoc_control
// assumes overload and level are commanded by the bench
`timescale 1ns/10ps
module bmoc_stage_model #(
  parameter int SS_CYC = 40
) (
  // controller and bench side
  input wire logic clk, rst_b, convert_on, soft_start_go, hold_low_on, overload,
  input wire logic [11:0] level,
  // sense side
  output logic soft_start_done, uv_below, low_over_limit, cycle_end, low_on,
  output logic [11:0] low_current
);
  int ss_cnt;     // ramp progress
  int droop_cnt;  // cycles of sagging output
  logic [2:0] ph; // switching phase
  assign low_over_limit = convert_on && overload;
  // the clamp stretches the low-side on-time
  assign low_on = convert_on && (ph[2] || hold_low_on);
  // outside the on-time the sample is junk
  assign low_current = low_on ? level : ~level;
  assign cycle_end = convert_on && ph == 3'h7;
  // a sustained overload drags the output under the threshold
  assign uv_below = convert_on && droop_cnt >= 16;
  assign soft_start_done = convert_on && ss_cnt >= SS_CYC;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      ph <= 3'h0;
      ss_cnt <= 0;
      droop_cnt <= 0;
    end
    else
    begin
      ph <= ph + 3'h1;
      ss_cnt <= !convert_on ? 0 : ss_cnt + int'(soft_start_go && ss_cnt < SS_CYC);
      droop_cnt <= !low_over_limit ? 0 : droop_cnt + int'(droop_cnt < 16);
    end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for bmoc_control with a stage model
// assumes bmoc_pkg compiled first; hiccup cut to 50 cycles
`timescale 1ns/10ps
module tb_top;
  import bmoc_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, reg_ack, enable_pin, overload, cycle_end;
  logic soft_start_done, uv_below, low_over_limit, convert_on, soft_start_go, low_on;
  logic hold_low_on, block_high_on, forced_continuous_select;
  logic [7:0] reg_addr;
  logic [1:0] fsw_code;
  logic [23:0] fsw_step, comp;
  logic [11:0] level, low_current, output_current_reading;
  bmoc_byte_t reg_wdata, reg_rdata, loop_gain_out, integrator_ramp_out, load_line_out, d;
  bmoc_byte_t regs [9] = '{8'h33, 8'h45, 8'h7B, 8'h7A, 8'hA0, 8'hA9, 8'hAA, 8'hAD, 8'h12};
  int n_errors = 0, check_count = 0, n;
  bmoc_control #(.HICCUP_CYC(50)) uut (.*);
  bmoc_stage_model u_stage (.*);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [23:0] step_of(input int c);
    return 24'(125000000 / (600000 + 200000 * c));
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input bmoc_byte_t a, v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    chk(reg_ack, 1);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input bmoc_byte_t a, e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    chk(reg_rdata, e);
  endtask
  // bounded wait for soft-start request or for shutdown
  task automatic wt(input bit go, output int k);
    k = 0;
    while ((go ? soft_start_go : !convert_on) !== 1'b1 && k < 2000)
    begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    {rst_b, reg_wr, reg_rd, enable_pin, overload} = 5'h0;
    reg_addr = 8'h0;
    reg_wdata = 8'h0;
    n = $urandom(32'hA98CA26F);
    level = 12'($urandom);
    comp = 24'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i]) rc(regs[i], 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h33, 8'(c));
      chk({fsw_code, fsw_step}, {2'(c), step_of(c)});
    end
    repeat (6)
    begin
      n = $urandom_range(2);
      d = 8'($urandom);
      wr(regs[5 + n], d);
      comp[16 - 8 * n +: 8] = d;
      chk({loop_gain_out, integrator_ramp_out, load_line_out}, comp);
      rc(regs[5 + n], d);
    end
    wr(8'h7B, 8'hFF);
    rc(8'h7B, 8'h00);
    $display("registers done");
    wr(8'hA0, 8'h01);
    wr(8'h45, 8'h01);
    chk(forced_continuous_select, 1);
    @(posedge clk) enable_pin <= 1'b1;
    wr(8'hA0, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk(forced_continuous_select, 1);
    @(posedge clk) enable_pin <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(forced_continuous_select, 0);
    $display("mode done");
    @(posedge clk) enable_pin <= 1'b1;
    @(posedge clk) overload <= 1'b1;
    repeat (24) @(posedge clk);
    #1 chk({convert_on, hold_low_on, block_high_on}, 3'h7);
    @(posedge clk) overload <= 1'b0;
    repeat (30) @(posedge clk);
    rc(8'h7B, 8'h01);
    rc(8'h7B, 8'h00);
    rc(8'h7A, 8'h00);
    chk(output_current_reading, level);
    $display("clamp done");
    repeat (2)
    begin
      @(posedge clk) overload <= 1'b1;
      repeat (900) @(posedge clk);
      @(posedge clk) overload <= 1'b0;
      repeat (4) @(posedge clk);
    end
    #1 chk(convert_on, 1);
    rc(8'h7A, 8'h01);
    @(posedge clk) overload <= 1'b1;
    wt(1'b0, n);
    chk(n > 1262 && n < 1274, 1);
    repeat (100) @(posedge clk);
    #1 chk(convert_on | hold_low_on, 0);
    @(posedge clk) overload <= 1'b0;
    enable_pin <= 1'b0;
    @(posedge clk) enable_pin <= 1'b1;
    wt(1'b1, n);
    chk(n < 4, 1);
    $display("latch done");
    repeat (60) @(posedge clk);
    wr(8'h45, 8'h09);
    @(posedge clk) overload <= 1'b1;
    repeat (2)
    begin
      wt(1'b0, n);
      wt(1'b1, n);
      chk(n > 47 && n < 54, 1);
    end
    @(posedge clk) overload <= 1'b0;
    $display("hiccup done");
    results();
  end
  initial
  begin
    repeat (15000) @(posedge clk);
    n_errors++;
    $display("[FAIL] %0t timeout", $time);
    results();
  end
endmodule
